// file: hw/mcucr_pkg.sv
package mcucr_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] OSC_CTRL_REG_ADDR = 8'hdb;
   localparam int         MAIN_OSC_OFF_BIT  = 0;
   localparam logic [7:0] OSC_CTRL_RESET    = 8'h00;

   // ***************************************************************
   // Divider ratios
   // ***************************************************************
   localparam int DIV_TIMER   = 12;
   localparam int DIV_CORE    = 13;
   localparam int DIV_ADC_LO  = 6;
   localparam int DIV_ADC_HI  = 12;
   localparam int DIV_CNT_W   = 4;

   // ***************************************************************
   // Reset stabilisation and oscillator timing
   // ***************************************************************
   localparam int RESET_STAB_CYCLES   = 2048;
   localparam int STAB_CNT_W          = 12;
   localparam int PIN_STRETCH_CYCLES  = 4;
   localparam int OSC_STARTUP_CYCLES  = 64;
   localparam int MISS_EDGE_CYCLES    = 8;
   localparam int AUX_HALF_PERIOD     = 4;
   localparam int MIN_INT_HALF_PERIOD = 2;
   localparam int TIME_CNT_W          = 8;

   typedef enum logic [2:0] {
      MCUCR_SRC_MAIN = 3'b001,
      MCUCR_SRC_SWAP = 3'b010,
      MCUCR_SRC_AUX  = 3'b100
   } mcucr_src_t;

endpackage : mcucr_pkg

// file: hw/mcucr_top.sv
// Implementation choice: the plain strobed port.
module mcucr_top
   import mcucr_pkg::*;
#(
   parameter int P_STAB_CYCLES = RESET_STAB_CYCLES
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_b,
   input  wire logic       i_main_osc,
   input  wire logic       i_reset_pin_b,
   input  wire logic       i_wdg_reset,
   input  wire logic       i_osc_safeguard,
   input  wire logic       i_adc_div_sel,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   output logic            o_int_clk_en,
   output logic            o_timer_clk_en,
   output logic            o_core_clk_en,
   output logic            o_adc_clk_en,
   output logic            o_aux_osc_on,
   output logic            o_main_osc_en,
   output logic            o_on_aux,
   output logic            o_int_reset_b,
   output logic            o_io_pullup_in
);

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   if (P_STAB_CYCLES < 1 || P_STAB_CYCLES >= (1 << STAB_CNT_W)) begin : g_bad_stab
      $error("P_STAB_CYCLES out of range");
   end
   if (DIV_TIMER > (1 << DIV_CNT_W) || DIV_CORE > (1 << DIV_CNT_W) || DIV_ADC_HI > (1 << DIV_CNT_W)) begin : g_bad_div
      $error("divider ratio too large for its counter");
   end
   if (OSC_STARTUP_CYCLES >= (1 << TIME_CNT_W) || MISS_EDGE_CYCLES >= (1 << TIME_CNT_W)) begin : g_bad_time
      $error("timing count too large for its counter");
   end
   if (AUX_HALF_PERIOD < 1 || PIN_STRETCH_CYCLES < 1) begin : g_bad_short
      $error("aux period and pin stretch need at least one cycle");
   end

   localparam logic [TIME_CNT_W-1:0] MISS_LIM  = TIME_CNT_W'(MISS_EDGE_CYCLES);
   localparam logic [TIME_CNT_W-1:0] START_LIM = TIME_CNT_W'(OSC_STARTUP_CYCLES);
   localparam logic [TIME_CNT_W-1:0] AUX_LIM   = TIME_CNT_W'(AUX_HALF_PERIOD - 1);
   localparam logic [TIME_CNT_W-1:0] GAP_LIM   = TIME_CNT_W'(MIN_INT_HALF_PERIOD);
   localparam logic [STAB_CNT_W-1:0] STAB_LIM  = STAB_CNT_W'(P_STAB_CYCLES - 1);
   localparam logic [TIME_CNT_W-1:0] STR_LIM   = TIME_CNT_W'(PIN_STRETCH_CYCLES - 1);

   function automatic logic div_last(input logic [DIV_CNT_W-1:0] c, input int n);
      div_last = (c == DIV_CNT_W'(n - 1));
   endfunction : div_last

   function automatic logic [DIV_CNT_W-1:0] div_next(input logic [DIV_CNT_W-1:0] c, input int n);
      div_next = div_last(c, n) ? '0 : c + 1'b1;
   endfunction : div_next

   // ***************************************************************
   // Register port
   // ***************************************************************
   logic                  main_osc_off_q;
   logic                  restart_req;
   logic                  hit;
   logic                  int_reset_b_q;
   assign hit = (i_addr == OSC_CTRL_REG_ADDR);

   // Internal reset wins over a write in the same cycle, so any reset restarts main.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         main_osc_off_q <= OSC_CTRL_RESET[MAIN_OSC_OFF_BIT];
      end else if (!int_reset_b_q) begin
         main_osc_off_q <= 1'b0;
      end else if (i_wr && hit && i_osc_safeguard) begin
         main_osc_off_q <= i_wdata[MAIN_OSC_OFF_BIT];
      end
   end
   // A clearing write restarts the start-up count even if the enable never dropped.
   assign restart_req = i_wr && hit && main_osc_off_q && !i_wdata[MAIN_OSC_OFF_BIT];

   // Read data stand for one cycle only; the port reads zero otherwise.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rdata <= '0;
      end else if (i_rd && hit) begin
         o_rdata <= {7'h00, main_osc_off_q};
      end else begin
         o_rdata <= '0;
      end
   end

   // ***************************************************************
   // Main oscillator enable and start-up timer
   // ***************************************************************
   logic [TIME_CNT_W-1:0] start_cnt_q;
   logic                  main_ready_q;

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_main_osc_en <= 1'b1;
      end else begin
         o_main_osc_en <= !(main_osc_off_q && i_osc_safeguard);
      end
   end

   // The start-up count runs on the system clock and starts over when the enable drops or a clearing write arrives.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         start_cnt_q  <= '0;
         main_ready_q <= 1'b0;
      end else if (!o_main_osc_en || restart_req) begin
         start_cnt_q  <= '0;
         main_ready_q <= 1'b0;
      end else if (start_cnt_q != START_LIM) begin
         start_cnt_q  <= start_cnt_q + 1'b1;
      end else begin
         main_ready_q <= 1'b1;
      end
   end

   // ***************************************************************
   // Main edge detection and spike filter
   // ***************************************************************
   logic                  main_d1_q;
   logic                  main_edge;
   logic [TIME_CNT_W-1:0] miss_cnt_q;
   logic [TIME_CNT_W-1:0] gap_cnt_q;
   logic                  main_tick;
   logic                  main_missing;

   assign main_edge = i_main_osc && !main_d1_q;

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         main_d1_q <= 1'b0;
      end else begin
         main_d1_q <= i_main_osc;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         miss_cnt_q <= MISS_LIM;
      end else if (main_edge && o_main_osc_en) begin
         miss_cnt_q <= '0;
      end else if (miss_cnt_q != MISS_LIM) begin
         miss_cnt_q <= miss_cnt_q + 1'b1;
      end
   end
   // Only edges of an enabled oscillator count, so a stopped oscillator reads as missing.
   assign main_missing = (miss_cnt_q == MISS_LIM);

   // With the safeguard strap set, edges closer than the minimum gap are treated as spikes and dropped.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gap_cnt_q <= GAP_LIM;
      end else if (main_tick) begin
         gap_cnt_q <= '0;
      end else if (gap_cnt_q != GAP_LIM) begin
         gap_cnt_q <= gap_cnt_q + 1'b1;
      end
   end
   assign main_tick = main_edge && o_main_osc_en && (!i_osc_safeguard || gap_cnt_q == GAP_LIM);

   // ***************************************************************
   // Auxiliary oscillator
   // ***************************************************************
   logic [TIME_CNT_W-1:0] aux_cnt_q;
   logic                  aux_tick;
   logic                  aux_want;

   // Without the safeguard strap there is no fallback, so a dead main leaves the block unclocked.
   assign aux_want = i_osc_safeguard && (main_missing || !main_ready_q);

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_aux_osc_on <= 1'b0;
      end else begin
         o_aux_osc_on <= aux_want;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         aux_cnt_q <= '0;
      end else if (!o_aux_osc_on || aux_cnt_q == AUX_LIM) begin
         aux_cnt_q <= '0;
      end else begin
         aux_cnt_q <= aux_cnt_q + 1'b1;
      end
   end
   assign aux_tick = o_aux_osc_on && (aux_cnt_q == AUX_LIM);

   // ***************************************************************
   // Source selection
   // ***************************************************************
   mcucr_src_t src_q;
   logic       int_tick;

   // Swapping waits one aux period so no shortened pulse reaches the core.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         src_q <= MCUCR_SRC_MAIN;
      end else begin
         unique case (src_q)
            MCUCR_SRC_MAIN: begin
               if (aux_want) begin
                  src_q <= MCUCR_SRC_SWAP;
               end
            end
            MCUCR_SRC_SWAP: begin
               if (aux_tick) begin
                  src_q <= MCUCR_SRC_AUX;
               end
            end
            MCUCR_SRC_AUX: begin
               if (!aux_want && main_tick) begin
                  src_q <= MCUCR_SRC_MAIN;
               end
            end
         endcase
      end
   end

   always_comb begin
      int_tick = 1'b0;
      unique case (src_q)
         MCUCR_SRC_MAIN: int_tick = main_tick;
         MCUCR_SRC_SWAP: int_tick = 1'b0;
         MCUCR_SRC_AUX:  int_tick = aux_tick;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_int_clk_en <= 1'b0;
      end else begin
         o_int_clk_en <= int_tick;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_on_aux <= 1'b0;
      end else begin
         o_on_aux <= (src_q == MCUCR_SRC_AUX);
      end
   end

   // ***************************************************************
   // Dividers
   // ***************************************************************
   logic [DIV_CNT_W-1:0] tmr_cnt_q;
   logic [DIV_CNT_W-1:0] core_cnt_q;
   logic [DIV_CNT_W-1:0] adc_cnt_q;
   int                   adc_div;

   assign adc_div = i_adc_div_sel ? DIV_ADC_HI : DIV_ADC_LO;

   // Each divider counts internal ticks and pulses on the last tick of its cycle.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tmr_cnt_q      <= '0;
         o_timer_clk_en <= 1'b0;
      end else begin
         o_timer_clk_en <= int_tick && div_last(tmr_cnt_q, DIV_TIMER);
         if (int_tick) begin
            tmr_cnt_q <= div_next(tmr_cnt_q, DIV_TIMER);
         end
      end
   end

   // Core pulses are held back during internal reset so nothing executes.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         core_cnt_q    <= '0;
         o_core_clk_en <= 1'b0;
      end else begin
         o_core_clk_en <= int_tick && div_last(core_cnt_q, DIV_CORE) && int_reset_b_q;
         if (int_tick) begin
            core_cnt_q <= div_next(core_cnt_q, DIV_CORE);
         end
      end
   end

   // A new converter ratio may leave the count past its end, so the wrap tests greater or equal.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         adc_cnt_q    <= '0;
         o_adc_clk_en <= 1'b0;
      end else begin
         o_adc_clk_en <= int_tick && div_last(adc_cnt_q, adc_div);
         if (int_tick) begin
            adc_cnt_q <= (adc_cnt_q >= DIV_CNT_W'(adc_div - 1)) ? '0 : adc_cnt_q + 1'b1;
         end
      end
   end

   // ***************************************************************
   // Reset combining, stretching and stabilisation delay
   // ***************************************************************
   logic [TIME_CNT_W-1:0] str_cnt_q;
   logic                  ext_rst_q;
   logic [STAB_CNT_W-1:0] stab_cnt_q;

   // A short low pulse on the pin is stretched to a few system clocks.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         str_cnt_q <= '0;
         ext_rst_q <= 1'b1;
      end else if (!i_reset_pin_b || i_wdg_reset) begin
         str_cnt_q <= '0;
         ext_rst_q <= 1'b1;
      end else if (str_cnt_q != STR_LIM) begin
         str_cnt_q <= str_cnt_q + 1'b1;
      end else begin
         ext_rst_q <= 1'b0;
      end
   end

   // ***************************************************************
   // Stabilisation delay
   // ***************************************************************
   // Power-on is the asynchronous reset itself; the count runs on whichever source clocks.
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         stab_cnt_q    <= '0;
         int_reset_b_q <= 1'b0;
      end else if (ext_rst_q) begin
         stab_cnt_q    <= '0;
         int_reset_b_q <= 1'b0;
      end else if (int_tick && !int_reset_b_q) begin
         if (stab_cnt_q == STAB_LIM) begin
            int_reset_b_q <= 1'b1;
         end else begin
            stab_cnt_q <= stab_cnt_q + 1'b1;
         end
      end
   end

   // ***************************************************************
   // Reset outputs
   // ***************************************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_int_reset_b  <= 1'b0;
         o_io_pullup_in <= 1'b1;
      end else begin
         o_int_reset_b  <= int_reset_b_q;
         o_io_pullup_in <= !int_reset_b_q;
      end
   end

endmodule : mcucr_top

// file: test/mcucr_osc_model.sv
module mcucr_osc_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_osc_en,
   input  wire logic       i_run,
   input  wire logic [3:0] i_half,
   output logic            o_main_osc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q = 4'h0;
   initial o_main_osc = 1'b0;
   always @(posedge i_clk_sys) begin
      if (i_osc_en && i_run) begin
         cnt_q <= (cnt_q + 4'h1 >= i_half) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q + 4'h1 >= i_half)
            o_main_osc <= ~o_main_osc;
      end else
         o_main_osc <= 1'b0;
   end
endmodule : mcucr_osc_model

// file: test/mcucr_top_sva.sv
module mcucr_top_sva
   import mcucr_pkg::*;
#(
   parameter int P_STAB_CYCLES = RESET_STAB_CYCLES
) (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_b,
   input wire logic       i_reset_pin_b,
   input wire logic       i_wdg_reset,
   input wire logic       i_osc_safeguard,
   input wire logic       i_adc_div_sel,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_int_clk_en,
   input wire logic       o_timer_clk_en,
   input wire logic       o_core_clk_en,
   input wire logic       o_adc_clk_en,
   input wire logic       o_aux_osc_on,
   input wire logic       o_main_osc_en,
   input wire logic       o_on_aux,
   input wire logic       o_int_reset_b
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);
   logic [4:0] cnt_q [3];
   logic [2:0] ok_q;
   logic       sel_q;
   wire  [2:0] pls = {o_adc_clk_en, o_core_clk_en, o_timer_clk_en};
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ok_q <= 3'b000;
         sel_q <= 1'b0;
         cnt_q <= '{default: 5'h00};
      end else begin
         sel_q <= i_adc_div_sel;
         for (int k = 0; k < 3; k++) begin
            cnt_q[k] <= pls[k] ? 5'h00 : cnt_q[k] + {4'h0, o_int_clk_en};
            ok_q[k] <= o_int_reset_b && !(k == 2 && i_adc_div_sel != sel_q) && (pls[k] || ok_q[k]);
         end
      end
   end
   timer_div_a: assert property (o_timer_clk_en && ok_q[0] |-> cnt_q[0] + {4'h0, o_int_clk_en} == 5'd12)
      else $error("timer enable spacing wrong");
   core_div_a: assert property (o_core_clk_en && ok_q[1] |-> cnt_q[1] + {4'h0, o_int_clk_en} == 5'd13)
      else $error("core enable spacing wrong");
   adc_div_a: assert property (o_adc_clk_en && ok_q[2] && i_adc_div_sel == sel_q |->
      cnt_q[2] + {4'h0, o_int_clk_en} == (sel_q ? 5'd12 : 5'd6)) else $error("converter enable spacing wrong");
   rd_idle_a: assert property (!($past(i_rd) && $past(i_addr) == OSC_CTRL_REG_ADDR) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
   pin_reset_a: assert property (!i_reset_pin_b |-> ##[1:3] !o_int_reset_b)
      else $error("pin low without internal reset");
   main_off_a: assert property (i_wr && i_addr == OSC_CTRL_REG_ADDR && i_wdata[0] && i_osc_safeguard
      && o_int_reset_b && i_reset_pin_b && !i_wdg_reset |-> ##2 !o_main_osc_en) else $error("main not stopped");
   strap_off_a: assert property (!i_osc_safeguard |-> !o_aux_osc_on && !o_on_aux)
      else $error("aux used without safeguard");
   spike_gap_a: assert property (o_int_clk_en && i_osc_safeguard |=> !o_int_clk_en [*2])
      else $error("internal ticks too close");
   core_hold_a: assert property (o_core_clk_en |-> o_int_reset_b)
      else $error("core clocked during internal reset");
   wdg_reset_a: assert property (i_wdg_reset |-> ##[1:3] !o_int_reset_b)
      else $error("watchdog without internal reset");
endmodule : mcucr_top_sva
bind mcucr_top mcucr_top_sva #(.P_STAB_CYCLES(P_STAB_CYCLES)) u_sva (.i_clk_sys, .i_rst_b, .i_reset_pin_b,
   .i_wdg_reset, .i_osc_safeguard, .i_adc_div_sel, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_int_clk_en,
   .o_timer_clk_en, .o_core_clk_en, .o_adc_clk_en, .o_aux_osc_on, .o_main_osc_en, .o_on_aux, .o_int_reset_b);

// file: test/mcucr_top_tb.sv
module mcucr_top_tb
   import mcucr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_clk_sys = 1'b0, i_rst_b = 1'b0, i_reset_pin_b = 1'b1, i_wdg_reset = 1'b0, i_osc_safeguard = 1'b1;
   logic        i_adc_div_sel = 1'b0, i_wr = 1'b0, i_rd = 1'b0, run = 1'b1, rd_q = 1'b0, i_main_osc;
   logic        o_int_clk_en, o_timer_clk_en, o_core_clk_en, o_adc_clk_en, o_aux_osc_on;
   logic        o_main_osc_en, o_on_aux, o_int_reset_b, o_io_pullup_in;
   logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, a, exp_q[$];
   logic [3:0]  half = 4'h3;
   logic [31:0] rnd = 32'h4;
   int          errors = 0, num_checks = 0, n, t;
   wire  [3:0]  mon = {o_int_reset_b, o_main_osc_en, o_on_aux, o_aux_osc_on};
   always #10 i_clk_sys = ~i_clk_sys;
   mcucr_top #(.P_STAB_CYCLES(16)) DUT (.i_clk_sys, .i_rst_b, .i_main_osc, .i_reset_pin_b, .i_wdg_reset,
      .i_osc_safeguard, .i_adc_div_sel, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_int_clk_en,
      .o_timer_clk_en, .o_core_clk_en, .o_adc_clk_en, .o_aux_osc_on, .o_main_osc_en, .o_on_aux,
      .o_int_reset_b, .o_io_pullup_in);
   mcucr_osc_model u_osc (.i_clk_sys, .i_osc_en(o_main_osc_en), .i_run(run), .i_half(half), .o_main_osc(i_main_osc));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] s;
      s = v ^ (v << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic chk(input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   task automatic wait_on(input int k, input logic v, input int lim);
      n = 0;
      while (mon[k] !== v && n < lim) begin
         @(posedge i_clk_sys);
         n++;
      end
      chk({7'h00, v}, {7'h00, mon[k]});
      if (mon[k] !== v)
         report_and_stop();
   endtask : wait_on
   task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
      if (!w)
         exp_q.push_back(d);
      i_addr <= ad;
      i_wdata <= d;
      {i_wr, i_rd} <= {w, !w};
      @(posedge i_clk_sys);
      {i_wr, i_rd} <= 2'b00;
      @(posedge i_clk_sys);
   endtask : acc
   always @(posedge i_clk_sys) begin
      if (rd_q)
         chk(exp_q.pop_front(), o_rdata);
      rd_q <= i_rd;
   end
   initial begin
      repeat (16) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      wait_on(3, 1'b1, 2000);
      acc(1'b0, OSC_CTRL_REG_ADDR, OSC_CTRL_RESET);
      acc(1'b1, OSC_CTRL_REG_ADDR, 8'hff);
      acc(1'b0, OSC_CTRL_REG_ADDR, 8'h01);
      wait_on(1, 1'b1, 100);
      wait_on(2, 1'b0, 1);
      rnd = xs(rnd);
      i_adc_div_sel <= rnd[16];
      a = (rnd[7:0] == OSC_CTRL_REG_ADDR) ? 8'h00 : rnd[7:0];
      acc(1'b1, a, rnd[15:8]);
      acc(1'b0, a, 8'h00);
      acc(1'b1, OSC_CTRL_REG_ADDR, 8'h00);
      wait_on(1, 1'b0, 400);
      chk(8'h01, 8'(n >= OSC_STARTUP_CYCLES - 8));
      wait_on(0, 1'b0, 20);
      run <= 1'b0;
      wait_on(1, 1'b1, 40);
      run <= 1'b1;
      wait_on(1, 1'b0, 400);
      half <= 4'h1;
      i_adc_div_sel <= rnd[17];
      repeat (100) @(posedge i_clk_sys);
      half <= 4'h3;
      i_wdg_reset <= 1'b1;
      @(posedge i_clk_sys);
      i_wdg_reset <= 1'b0;
      wait_on(3, 1'b0, 4);
      wait_on(3, 1'b1, 2000);
      i_reset_pin_b <= 1'b0;
      repeat (100) @(posedge i_clk_sys);
      chk(8'h01, {o_int_reset_b, 6'h00, o_io_pullup_in});
      i_reset_pin_b <= 1'b1;
      t = 0;
      n = 0;
      while (o_int_reset_b !== 1'b1 && n < 2000) begin
         @(posedge i_clk_sys);
         t += o_int_clk_en;
         n++;
      end
      chk(8'h01, 8'(t inside {[16:18]}));
      chk(8'h02, {6'h00, o_int_reset_b, o_io_pullup_in});
      if (o_int_reset_b !== 1'b1)
         report_and_stop();
      i_rst_b <= 1'b0;
      i_osc_safeguard <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      wait_on(3, 1'b1, 2000);
      acc(1'b1, OSC_CTRL_REG_ADDR, 8'h01);
      acc(1'b0, OSC_CTRL_REG_ADDR, 8'h00);
      wait_on(2, 1'b1, 1);
      report_and_stop();
   end
endmodule : mcucr_top_tb
